// ### cocc_pkg.sv
// cocc_pkg: constants and types for the compare output control slice
// assumes an axi4-lite master and a single 40 MHz clock
//
// Summary of operation
// - stop-in-idle bit set halts the channel while cpu idles; clear keeps running
// - clock select 111 peripheral clock, 000 timer two, 110/101 reserved
// - fault a enable set makes channel respond to fault pin; clear ignores it
// - fault status set by hardware on fault pin, zero when no fault occurred
// - trigger mode one: status clears on secondary equal timer or software
// - compare values double-buffered only in pwm mode, else written directly
package cocc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_PRI_CMP = 8'h08;
  localparam logic [7:0] OFS_SEC_CMP = 8'h0C;
  localparam logic [7:0] OFS_TIMER = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // ----------------------------------------------------------------
  // control one and control two field positions
  // ----------------------------------------------------------------
  localparam int POS_IDLE_STOP = 13;
  localparam int POS_TSEL_LO = 10;
  localparam int POS_FAULT_EN = 7;
  localparam int POS_FAULT_FLAG = 4;
  localparam int POS_TRIG_MODE = 3;
  localparam int POS_TRIG_STAT = 7;
  localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_ONE_WMASK = 16'h3C8F;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] TSEL_PERIPH = 3'h7;
  localparam logic [2:0] TSEL_RSV_A = 3'h6;
  localparam logic [2:0] TSEL_RSV_B = 3'h5;
  localparam logic [2:0] MODE_PWM_A = 3'h6;
  localparam logic [2:0] MODE_PWM_B = 3'h7;
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_TRIG_CLR = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic idle_stop_ctl;
    logic [2:0] timebase_clock_sel;
    logic fault_a_input_en;
    logic trigger_clear_mode;
    logic [2:0] channel_mode_sel;
  } cocc_ctrl_t;
endpackage : cocc_pkg

// ### cocc_top.sv
// cocc_top: control slice of one output compare channel behind axi4-lite
// assumes clock sources arrive as one-cycle tick inputs synchronous to aclk
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cocc_top #(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system and pins
  input wire logic cpu_idle,
  input wire logic peripheral_clock_tick,
  input wire logic [4:0] timer_tick,
  input wire logic fault_a_pin,
  input wire logic period_end,
  // channel outputs
  output logic compare_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cocc_pkg::cocc_ctrl_t ctrl_q;
  logic fault_flag_q;
  logic trig_stat_q;
  logic [TIMER_W-1:0] pri_q, sec_q, pri_act_q, sec_act_q, tmr_q;
  logic [cocc_pkg::IRQ_W-1:0] stat_q, mask_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic tick;
  logic run;
  logic pwm_mode;
  logic wr_fire;
  logic rd_fire;
  logic fault_ev, match_ev, trig_clr_ev;
  logic sw_trig_clr, sw_fault_clr;
  logic [TIMER_W-1:0] wr_val;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  always_comb begin
    if (ctrl_q.timebase_clock_sel == cocc_pkg::TSEL_PERIPH) begin
      tick = peripheral_clock_tick;
    end else if (ctrl_q.timebase_clock_sel == cocc_pkg::TSEL_RSV_A ||
                 ctrl_q.timebase_clock_sel == cocc_pkg::TSEL_RSV_B) begin
      tick = 1'b0;
    end else begin
      tick = timer_tick[ctrl_q.timebase_clock_sel];
    end
  end
  assign run = !(ctrl_q.idle_stop_ctl && cpu_idle);
  assign pwm_mode = ctrl_q.channel_mode_sel == cocc_pkg::MODE_PWM_A ||
                    ctrl_q.channel_mode_sel == cocc_pkg::MODE_PWM_B;
  assign match_ev = run && tick && tmr_q == sec_act_q;
  assign fault_ev = ctrl_q.fault_a_input_en && fault_a_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_q <= '0;
    end else if (run && tick) begin
      tmr_q <= match_ev ? '0 : tmr_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_out <= 1'b0;
    end else if (fault_flag_q || ctrl_q.channel_mode_sel == 3'h0) begin
      compare_out <= 1'b0;
    end else if (run && tick) begin
      compare_out <= tmr_q < pri_act_q;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write
  // ----------------------------------------------------------------
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_val = wdata_q[TIMER_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cocc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= cocc_pkg::OFS_IRQ_MASK && awaddr_q[1:0] == 2'b00)
                       ? cocc_pkg::RESP_OKAY : cocc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      mask_q <= '0;
    end else if (wr_fire && awaddr_q == cocc_pkg::OFS_CTRL_ONE) begin
      if (wstrb_q[1]) begin
        ctrl_q.idle_stop_ctl <= wdata_q[cocc_pkg::POS_IDLE_STOP];
        ctrl_q.timebase_clock_sel <= wdata_q[cocc_pkg::POS_TSEL_LO +: 3];
      end
      if (wstrb_q[0]) begin
        ctrl_q.fault_a_input_en <= wdata_q[cocc_pkg::POS_FAULT_EN];
        ctrl_q.trigger_clear_mode <= wdata_q[cocc_pkg::POS_TRIG_MODE];
        ctrl_q.channel_mode_sel <= wdata_q[2:0];
      end
    end else if (wr_fire && awaddr_q == cocc_pkg::OFS_IRQ_MASK && wstrb_q[0]) begin
      mask_q <= wdata_q[cocc_pkg::IRQ_W-1:0];
    end
  end

  assign sw_fault_clr = wr_fire && awaddr_q == cocc_pkg::OFS_CTRL_ONE && wstrb_q[0] &&
                        !wdata_q[cocc_pkg::POS_FAULT_FLAG];
  assign sw_trig_clr = wr_fire && awaddr_q == cocc_pkg::OFS_CTRL_TWO && wstrb_q[0] &&
                       !wdata_q[cocc_pkg::POS_TRIG_STAT];
  assign trig_clr_ev = ctrl_q.trigger_clear_mode && match_ev && trig_stat_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_flag_q <= 1'b0;
    end else if (fault_ev) begin
      fault_flag_q <= 1'b1;
    end else if (sw_fault_clr) begin
      fault_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_stat_q <= 1'b0;
    end else if (wr_fire && awaddr_q == cocc_pkg::OFS_CTRL_TWO && wstrb_q[0] &&
                 wdata_q[cocc_pkg::POS_TRIG_STAT]) begin
      trig_stat_q <= 1'b1;
    end else if (trig_clr_ev || sw_trig_clr) begin
      trig_stat_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // compare values and their active copies
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_q <= cocc_pkg::CMP_RESET;
      sec_q <= cocc_pkg::CMP_RESET;
    end else if (wr_fire && awaddr_q == cocc_pkg::OFS_PRI_CMP) begin
      pri_q <= wr_val;
    end else if (wr_fire && awaddr_q == cocc_pkg::OFS_SEC_CMP) begin
      sec_q <= wr_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_act_q <= cocc_pkg::CMP_RESET;
      sec_act_q <= cocc_pkg::CMP_RESET;
    end else if (!pwm_mode || period_end || match_ev) begin
      pri_act_q <= pri_q;
      sec_act_q <= sec_q;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, cleared by reading it
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < cocc_pkg::IRQ_W; i++) begin
        if ((i == cocc_pkg::IRQ_FAULT && fault_ev && !fault_flag_q) ||
            (i == cocc_pkg::IRQ_MATCH && match_ev) ||
            (i == cocc_pkg::IRQ_TRIG_CLR && trig_clr_ev)) begin
          stat_q[i] <= 1'b1;
        end else if (rd_fire && s_axi_araddr == cocc_pkg::OFS_IRQ_STAT) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read
  // ----------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cocc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= cocc_pkg::RESP_OKAY;
        s_axi_rdata <= '0;
        if (s_axi_araddr == cocc_pkg::OFS_CTRL_ONE) begin
          s_axi_rdata[cocc_pkg::POS_IDLE_STOP] <= ctrl_q.idle_stop_ctl;
          s_axi_rdata[cocc_pkg::POS_TSEL_LO +: 3] <= ctrl_q.timebase_clock_sel;
          s_axi_rdata[cocc_pkg::POS_FAULT_EN] <= ctrl_q.fault_a_input_en;
          s_axi_rdata[cocc_pkg::POS_FAULT_FLAG] <= fault_flag_q;
          s_axi_rdata[cocc_pkg::POS_TRIG_MODE] <= ctrl_q.trigger_clear_mode;
          s_axi_rdata[2:0] <= ctrl_q.channel_mode_sel;
        end else if (s_axi_araddr == cocc_pkg::OFS_CTRL_TWO) begin
          s_axi_rdata[cocc_pkg::POS_TRIG_STAT] <= trig_stat_q;
        end else if (s_axi_araddr == cocc_pkg::OFS_PRI_CMP) begin
          s_axi_rdata[TIMER_W-1:0] <= pri_q;
        end else if (s_axi_araddr == cocc_pkg::OFS_SEC_CMP) begin
          s_axi_rdata[TIMER_W-1:0] <= sec_q;
        end else if (s_axi_araddr == cocc_pkg::OFS_TIMER) begin
          s_axi_rdata[TIMER_W-1:0] <= tmr_q;
        end else if (s_axi_araddr == cocc_pkg::OFS_IRQ_STAT) begin
          s_axi_rdata[cocc_pkg::IRQ_W-1:0] <= stat_q;
        end else if (s_axi_araddr == cocc_pkg::OFS_IRQ_MASK) begin
          s_axi_rdata[cocc_pkg::IRQ_W-1:0] <= mask_q;
        end else begin
          s_axi_rresp <= cocc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  idle_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q.idle_stop_ctl && cpu_idle |=> $stable(tmr_q))
    else $error("timer moved while halted in idle");
  idle_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q.idle_stop_ctl && tick && !match_ev |=> tmr_q != $past(tmr_q))
    else $error("timer stalled with idle stop clear");
  rsvd_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q.timebase_clock_sel == cocc_pkg::TSEL_RSV_A ||
    ctrl_q.timebase_clock_sel == cocc_pkg::TSEL_RSV_B |=> $stable(tmr_q))
    else $error("reserved clock select advanced timer");
  fault_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q.fault_a_input_en && !fault_flag_q && !sw_fault_clr |=> !fault_flag_q)
    else $error("fault flag set with input disabled");
  fault_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_ev |=> fault_flag_q ##1 !compare_out)
    else $error("fault not flagged or output not forced low");
  trig_auto_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_clr_ev && !(wr_fire && awaddr_q == cocc_pkg::OFS_CTRL_TWO) |=> !trig_stat_q)
    else $error("trigger status not cleared on match");
  trig_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q.trigger_clear_mode && trig_stat_q && !sw_trig_clr |=> trig_stat_q)
    else $error("trigger status cleared by hardware");
  direct_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pwm_mode && $past(!pwm_mode) |-> pri_act_q == $past(pri_q))
    else $error("compare value buffered outside pwm mode");
  zero_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && s_axi_araddr == cocc_pkg::OFS_CTRL_ONE |=>
      s_axi_rdata[31:14] == '0 && s_axi_rdata[9:8] == '0 && s_axi_rdata[6:5] == '0)
    else $error("unimplemented bits read nonzero");
  fault_cov_c: cover property (@(posedge aclk) fault_ev ##1 irq);
  match_cov_c: cover property (@(posedge aclk) trig_clr_ev);
  pwm_cov_c: cover property (@(posedge aclk) pwm_mode && period_end);
endmodule : cocc_top

// ### cocc_partner.sv
// cocc_partner: timer clock sources and the fault pin beside the channel
// assumes one aclk domain; the bench asks for a fault through fault_cmd
`timescale 1ns/1ps
module cocc_partner (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command from bench
  input wire logic fault_cmd,
  // sources toward the channel
  output logic peripheral_clock_tick,
  output logic [4:0] timer_tick,
  output logic fault_a_pin
);
  logic [3:0] div_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // peripheral clock every cycle, timer n when the 4-bit divider count is a multiple of n+2
  always_ff @(posedge aclk) begin
    peripheral_clock_tick <= aresetn;
    for (int i = 0; i < 5; i++) begin
      timer_tick[i] <= aresetn && ((div_q % (i + 2)) == 0);
    end
    fault_a_pin <= fault_cmd;
  end
endmodule : cocc_partner

// ### tb_compare_output_control.sv
// tb_compare_output_control: self-checking bench for cocc_top
// assumes cocc_partner supplies clock ticks and the fault pin
`timescale 1ns/1ps
module tb_compare_output_control;
  localparam logic [7:0] A_C1 = cocc_pkg::OFS_CTRL_ONE;
  localparam logic [7:0] A_C2 = cocc_pkg::OFS_CTRL_TWO;
  localparam logic [7:0] A_PRI = cocc_pkg::OFS_PRI_CMP;
  localparam logic [7:0] A_SEC = cocc_pkg::OFS_SEC_CMP;
  localparam logic [7:0] A_TMR = cocc_pkg::OFS_TIMER;
  localparam logic [7:0] A_ST = cocc_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] A_MSK = cocc_pkg::OFS_IRQ_MASK;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cpu_idle = 1'b0;
  logic period_end = 1'b0;
  logic fault_cmd = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, per_tick, fault_pin, cmp_out, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata;
  logic [4:0] tmr_tick;
  int n_mismatch = 0;
  int tests_run = 0;

  always #12.5 aclk = ~aclk;

  cocc_top i_cocc_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_idle(cpu_idle), .peripheral_clock_tick(per_tick), .timer_tick(tmr_tick),
    .fault_a_pin(fault_pin), .period_end(period_end), .compare_out(cmp_out), .irq(irq)
  );

  cocc_partner i_cocc_partner (
    .aclk(aclk), .aresetn(aresetn), .fault_cmd(fault_cmd),
    .peripheral_clock_tick(per_tick), .timer_tick(tmr_tick), .fault_a_pin(fault_pin)
  );

  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic moves(output logic m);
    logic [31:0] t0, t1;
    rd(A_TMR, t0);
    tick(20);
    rd(A_TMR, t1);
    m = (t1 !== t0);
  endtask : moves

  task automatic pulse;
    period_end <= 1'b1;
    @(posedge aclk);
    period_end <= 1'b0;
    tick(4);
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map;
    logic [31:0] d;
    rd(A_C1, d);
    chk("ctrl one reset", {16'h0000, cocc_pkg::CTRL_ONE_RESET}, d);
    wr(A_C1, 32'hFFFF_FFFF);
    rd(A_C1, d);
    chk("ctrl one readback", {16'h0000, cocc_pkg::CTRL_ONE_WMASK}, d);
    rd(8'h20, d);
    chk("unmapped resp", {30'h0000_0000, cocc_pkg::RESP_SLVERR}, {30'h0000_0000, rsp});
    chk("unmapped data", 32'h0000_0000, d);
    wr(8'h20, 32'h0000_0000);
    chk("unmapped write resp", {30'h0000_0000, cocc_pkg::RESP_SLVERR}, {30'h0000_0000, rsp});
  endtask : t_reset_map

  task automatic t_timebase;
    logic m;
    wr(A_SEC, 32'h0000_FFFF);
    for (int c = 0; c < 8; c++) begin
      wr(A_C1, 32'h0000_0001 | (32'(c) << 10));
      moves(m);
      chk("timer runs per select", {31'h0000_0000, c != 5 && c != 6}, {31'h0000_0000, m});
    end
  endtask : t_timebase

  task automatic t_idle;
    logic m;
    for (int s = 0; s < 2; s++) begin
      wr(A_C1, 32'h0000_1C01 | (32'(s) << 13));
      cpu_idle <= 1'b1;
      moves(m);
      cpu_idle <= 1'b0;
      chk("timer runs in idle", {31'h0000_0000, s == 0}, {31'h0000_0000, m});
    end
  endtask : t_idle

  task automatic t_fault;
    logic [31:0] d;
    wr(A_MSK, 32'h0000_0001);
    wr(A_C1, 32'h0000_1C01);
    fault_cmd <= 1'b1;
    tick(4);
    rd(A_C1, d);
    chk("fault flag ignored", 32'h0000_0000, d & 32'h0000_0010);
    rd(A_ST, d);
    chk("fault status ignored", 32'h0000_0000, d & 32'h0000_0001);
    wr(A_C1, 32'h0000_1C81);
    tick(4);
    rd(A_C1, d);
    chk("fault flag set", 32'h0000_0010, d & 32'h0000_0010);
    chk("irq on fault", 32'h0000_0001, {31'h0000_0000, irq});
    fault_cmd <= 1'b0;
    tick(4);
    wr(A_C1, 32'h0000_1C81);
    rd(A_C1, d);
    chk("fault flag cleared", 32'h0000_0000, d & 32'h0000_0010);
    rd(A_ST, d);
    chk("fault status", 32'h0000_0001, d & 32'h0000_0001);
    tick(2);
    chk("irq after read", 32'h0000_0000, {31'h0000_0000, irq});
  endtask : t_fault

  task automatic t_trigger;
    logic [31:0] d;
    // bring the timer under the short period through a buffered match
    wr(A_C1, 32'h0000_1C06);
    rd(A_TMR, d);
    wr(A_SEC, d + 32'h0000_0020);
    pulse();
    wr(A_SEC, 32'h0000_0008);
    tick(32);
    for (int m = 0; m < 2; m++) begin
      wr(A_C1, 32'h0000_1C01 | (32'(m) << 3));
      wr(A_C2, 32'h0000_0080);
      tick(40);
      rd(A_C2, d);
      chk("trigger status", (m == 0) ? 32'h0000_0080 : 32'h0000_0000, d & 32'h0000_0080);
    end
    rd(A_ST, d);
    chk("match and auto clear status", 32'h0000_0006, d & 32'h0000_0006);
  endtask : t_trigger

  task automatic t_buffer;
    wr(A_SEC, 32'h0000_FFFF);
    wr(A_C1, 32'h0000_1C01);
    wr(A_PRI, 32'h0000_FFFF);
    tick(4);
    chk("direct load high", 32'h0000_0001, {31'h0000_0000, cmp_out});
    wr(A_C1, 32'h0000_1C00);
    tick(4);
    chk("mode off output low", 32'h0000_0000, {31'h0000_0000, cmp_out});
    wr(A_C1, 32'h0000_1C01);
    tick(4);
    wr(A_PRI, 32'h0000_0000);
    tick(4);
    chk("direct load low", 32'h0000_0000, {31'h0000_0000, cmp_out});
    for (int md = 6; md < 8; md++) begin
      wr(A_C1, 32'h0000_1C00 | 32'(md));
      wr(A_PRI, 32'h0000_FFFF);
      pulse();
      chk("pwm load high", 32'h0000_0001, {31'h0000_0000, cmp_out});
      wr(A_PRI, 32'h0000_0000);
      tick(4);
      chk("pwm value held", 32'h0000_0001, {31'h0000_0000, cmp_out});
      pulse();
      chk("pwm load low", 32'h0000_0000, {31'h0000_0000, cmp_out});
    end
  endtask : t_buffer

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    tick(2);
    aresetn <= 1'b1;
    t_reset_map();
    t_timebase();
    t_idle();
    t_fault();
    t_trigger();
    t_buffer();
    print_verdict();
  end

  initial begin
    tick(20000);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_compare_output_control
